/* hw/smcg_apb_regs.v */
// Purpose: APB slave holding the sleep control registers
// Assumes: zero wait states, 32-bit data
// Notes:   unmapped addresses read zero and report pslverr
`include "smcg_regs.vh"
module smcg_apb_regs (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        se_clear,
    input  wire [7:0]  status_in,
    output reg  [5:0]  ctrl_reg,
    output reg  [1:0]  tmask_reg,
    output reg  [15:0] startup_reg
);

wire access_en = psel & penable;
wire mapped    = (paddr == `SMCG_ADDR_CTRL) | (paddr == `SMCG_ADDR_TMASK) |
                 (paddr == `SMCG_ADDR_STATUS) | (paddr == `SMCG_ADDR_STARTUP);

assign pready  = 1'b1;
assign pslverr = access_en & ~mapped;

////////////////////////////////////////////////////////////////////////////////
always @(posedge core_clk) begin
    if (reset) begin
        ctrl_reg    <= 6'h00;
        tmask_reg   <= 2'h0;
        startup_reg <= `SMCG_STARTUP_RESET;
    end else begin
        if (access_en && pwrite && paddr == `SMCG_ADDR_CTRL)
            ctrl_reg <= pwdata[5:0];
        else if (se_clear)
            ctrl_reg[`SMCG_CTRL_SE_BIT] <= 1'b0;
        if (access_en && pwrite && paddr == `SMCG_ADDR_TMASK)
            tmask_reg <= pwdata[1:0];
        if (access_en && pwrite && paddr == `SMCG_ADDR_STARTUP)
            startup_reg <= pwdata[15:0];
    end
end

always @* begin
    case (paddr)
        `SMCG_ADDR_CTRL:    prdata = {26'h0000000, ctrl_reg};
        `SMCG_ADDR_TMASK:   prdata = {30'h00000000, tmask_reg};
        `SMCG_ADDR_STATUS:  prdata = {24'h000000, status_in};
        `SMCG_ADDR_STARTUP: prdata = {16'h0000, startup_reg};
        default:            prdata = 32'h00000000;
    endcase
end

endmodule // smcg_apb_regs

/* hw/smcg_regs.vh */
// Purpose: constants for the sleep mode clock gating block
// Assumes: APB register map, 32-bit data, one aligned word each
// Notes:   included by the APB register and sleep controller files
`ifndef SMCG_REGS_VH
`define SMCG_REGS_VH

// register byte addresses
`define SMCG_ADDR_CTRL      8'h00
`define SMCG_ADDR_TMASK     8'h04
`define SMCG_ADDR_STATUS    8'h08
`define SMCG_ADDR_STARTUP   8'h0C

// control register fields
`define SMCG_CTRL_SE_BIT    3
`define SMCG_CTRL_SM_LSB    0
`define SMCG_CTRL_SM_MSB    2
`define SMCG_CTRL_AS2_BIT   4
`define SMCG_CTRL_XTAL_BIT  5

// timer interrupt mask fields
`define SMCG_TMASK_OVF_BIT  0
`define SMCG_TMASK_CMP_BIT  1

// sleep mode select encodings
`define SMCG_SM_IDLE        3'h0
`define SMCG_SM_ADCNR       3'h1
`define SMCG_SM_PDOWN       3'h2
`define SMCG_SM_PSAVE       3'h3
`define SMCG_SM_RSV4        3'h4
`define SMCG_SM_RSV5        3'h5
`define SMCG_SM_STBY        3'h6
`define SMCG_SM_XSTBY       3'h7

// timing in cycles
`define SMCG_HALT_CYCLES    16'h0004
`define SMCG_STBY_CYCLES    16'h0006
`define SMCG_STARTUP_RESET  16'h0040

`endif

/* hw/smcg_sleep_ctrl.v */
// Purpose: sleep mode controller with clock gating and wake timing
// Assumes: one clock core_clk, synchronous active-high reset
// Notes:   gates are enables for downstream clock gate cells
//
// Operation
// - sleep only when sleep enable set
// - select 000 idle, 001 adc, 010 powerdown
// - wake holds cpu four extra cycles
// - power-down wake waits fuse start-up period
// - select 011 is power-save
// - power-save keeps timer2 running when async
// - timer2 wake needs mask and global enable
// - timer2 undefined in power-save unless async
// - power-save stops all but async clock
// - select 110 with crystal is standby
// - select 111 with crystal is extended standby
// - standby modes wake in six cycles
// - per-mode clock gating table
// - async clock and osc only with async bit (async clock also runs while awake and in idle and adc without it)
// - deep modes wake on irq2 or levels
// - standby modes need crystal clock source
// - encodings 100 and 101 are reserved
//
// Added by the designer: register access over APB and the placing of the registers.
`include "smcg_regs.vh"
module smcg_sleep_ctrl (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        sleep_instr,
    input  wire        global_irq_enable,
    input  wire        irq_pending,
    input  wire        ext_irq_zero,
    input  wire        ext_irq_one,
    input  wire        ext_irq_two,
    input  wire        ext_irq_zero_level,
    input  wire        ext_irq_one_level,
    input  wire        two_wire_match,
    input  wire        timer2_overflow,
    input  wire        timer2_compare,
    input  wire        spm_ready,
    input  wire        adc_done,
    input  wire        other_io_irq,
    output reg         core_clock_en,
    output reg         program_memory_clock_en,
    output reg         peripheral_io_clock_en,
    output reg         converter_clock_en,
    output reg         async_timer_clock_en,
    output reg         main_osc_en,
    output reg         timer_osc_en,
    output reg         cpu_halt,
    output reg         wake_event,
    output reg         timer2_undefined
);

localparam ST_RUN   = 2'h0;
localparam ST_SLEEP = 2'h1;
localparam ST_START = 2'h2;
localparam ST_HALT  = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// register file
wire [5:0]  ctrl_reg;
wire [1:0]  tmask_reg;
wire [15:0] startup_reg;
reg  [1:0]  state_reg;
reg  [2:0]  mode_reg;
reg         se_clear;
wire [7:0]  status_word;

assign status_word = {3'h0, timer2_undefined, mode_reg, state_reg != ST_RUN};

smcg_apb_regs u_regs (
    .core_clk    (core_clk),
    .reset       (reset),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .se_clear    (se_clear),
    .status_in   (status_word),
    .ctrl_reg    (ctrl_reg),
    .tmask_reg   (tmask_reg),
    .startup_reg (startup_reg)
);

wire       sleep_enable_bit       = ctrl_reg[`SMCG_CTRL_SE_BIT];
wire [2:0] sleep_mode_select      = ctrl_reg[`SMCG_CTRL_SM_MSB:`SMCG_CTRL_SM_LSB];
wire       timer2_async_clock_bit = ctrl_reg[`SMCG_CTRL_AS2_BIT];
wire       xtal_source            = ctrl_reg[`SMCG_CTRL_XTAL_BIT];

////////////////////////////////////////////////////////////////////////////////
// input synchronisers for pins and async-timer events
wire [5:0] raw_async = {timer2_compare, timer2_overflow, ext_irq_one_level,
                        ext_irq_zero_level, ext_irq_two, two_wire_match};
wire [5:0] sync_async;

smcg_sync2 #(.WIDTH(6)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (raw_async),
    .sync_out (sync_async)
);

wire s_twi   = sync_async[0];
wire s_irq2  = sync_async[1];
wire s_lvl0  = sync_async[2];
wire s_lvl1  = sync_async[3];
wire s_t2ovf = sync_async[4];
wire s_t2cmp = sync_async[5];

////////////////////////////////////////////////////////////////////////////////
// mode decode
function valid_mode;
    input [2:0] sm;
    input       xtal;
    begin
        case (sm)
            `SMCG_SM_IDLE, `SMCG_SM_ADCNR,
            `SMCG_SM_PDOWN, `SMCG_SM_PSAVE: valid_mode = 1'b1;
            `SMCG_SM_STBY, `SMCG_SM_XSTBY:  valid_mode = xtal;
            default:                        valid_mode = 1'b0;
        endcase
    end
endfunction

function has_async;
    input [2:0] sm;
    begin
        has_async = (sm == `SMCG_SM_PSAVE) || (sm == `SMCG_SM_XSTBY);
    end
endfunction

wire sleep_take = sleep_instr && sleep_enable_bit &&
                  valid_mode(sleep_mode_select, xtal_source);

////////////////////////////////////////////////////////////////////////////////
// wake qualification
reg wake_src;
always @* begin
    wake_src = 1'b0;
    case (mode_reg)
        `SMCG_SM_IDLE:
            wake_src = irq_pending | ext_irq_zero | ext_irq_one | s_irq2 |
                       s_twi | s_t2ovf | s_t2cmp | spm_ready | adc_done |
                       other_io_irq;
        `SMCG_SM_ADCNR:
            wake_src = s_irq2 | s_lvl0 | s_lvl1 | s_twi | s_t2ovf | s_t2cmp |
                       spm_ready | adc_done;
        `SMCG_SM_PDOWN, `SMCG_SM_STBY:
            wake_src = s_irq2 | s_lvl0 | s_lvl1 | s_twi;
        `SMCG_SM_PSAVE, `SMCG_SM_XSTBY:
            wake_src = s_irq2 | s_lvl0 | s_lvl1 | s_twi |
                       (timer2_async_clock_bit & global_irq_enable &
                        ((s_t2ovf & tmask_reg[`SMCG_TMASK_OVF_BIT]) |
                         (s_t2cmp & tmask_reg[`SMCG_TMASK_CMP_BIT])));
        default:
            wake_src = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// sleep sequencer
reg [15:0] count_reg;
reg [1:0]  state_next;
reg [2:0]  mode_next;
reg [15:0] count_next;
reg        se_clear_next;
reg        wake_event_next;
reg        timer2_undefined_next;

always @* begin
    state_next            = state_reg;
    mode_next             = mode_reg;
    count_next            = count_reg;
    se_clear_next         = 1'b0;
    wake_event_next       = 1'b0;
    timer2_undefined_next = timer2_undefined;
    case (state_reg)
        ST_RUN: begin
            if (sleep_take) begin
                state_next = ST_SLEEP;
                mode_next  = sleep_mode_select;
                if (sleep_mode_select == `SMCG_SM_PSAVE)
                    timer2_undefined_next = ~timer2_async_clock_bit;
            end
        end
        ST_SLEEP: begin
            if (wake_src) begin
                wake_event_next = 1'b1;
                case (mode_reg)
                    `SMCG_SM_PDOWN, `SMCG_SM_PSAVE: begin
                        state_next = ST_START;
                        count_next = startup_reg;
                    end
                    `SMCG_SM_STBY, `SMCG_SM_XSTBY: begin
                        state_next = ST_START;
                        count_next = `SMCG_STBY_CYCLES;
                    end
                    default: begin
                        state_next = ST_HALT;
                        count_next = `SMCG_HALT_CYCLES;
                    end
                endcase
            end
        end
        ST_START: begin
            if (count_reg <= 16'h0001) begin
                state_next = ST_HALT;
                count_next = `SMCG_HALT_CYCLES;
            end else begin
                count_next = count_reg - 16'h0001;
            end
        end
        ST_HALT: begin
            if (count_reg <= 16'h0001) begin
                state_next    = ST_RUN;
                se_clear_next = 1'b1;
            end else begin
                count_next = count_reg - 16'h0001;
            end
        end
        default: state_next = ST_RUN;
    endcase
end

always @(posedge core_clk) begin
    if (reset) begin
        state_reg        <= ST_RUN;
        mode_reg         <= `SMCG_SM_IDLE;
        count_reg        <= 16'h0000;
        se_clear         <= 1'b0;
        wake_event       <= 1'b0;
        timer2_undefined <= 1'b0;
    end else begin
        state_reg        <= state_next;
        mode_reg         <= mode_next;
        count_reg        <= count_next;
        se_clear         <= se_clear_next;
        wake_event       <= wake_event_next;
        timer2_undefined <= timer2_undefined_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// per-mode domain decode
function io_kept;
    input [2:0] sm;
    begin
        io_kept = (sm == `SMCG_SM_IDLE);
    end
endfunction

function adc_kept;
    input [2:0] sm;
    begin
        adc_kept = (sm == `SMCG_SM_IDLE) || (sm == `SMCG_SM_ADCNR);
    end
endfunction

function osc_kept;
    input [2:0] sm;
    begin
        osc_kept = adc_kept(sm) || (sm == `SMCG_SM_STBY) || (sm == `SMCG_SM_XSTBY);
    end
endfunction

function tosc_stopped;
    input [2:0] sm;
    begin
        tosc_stopped = (sm == `SMCG_SM_PDOWN) || (sm == `SMCG_SM_STBY);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// clock domain enables
wire asleep    = (state_reg == ST_SLEEP);
wire gated     = asleep || (state_reg == ST_START);
wire halt_last = (state_reg == ST_HALT) && (count_reg <= 16'h0001);

reg core_clock_en_next;
reg program_memory_clock_en_next;
reg peripheral_io_clock_en_next;
reg converter_clock_en_next;
reg async_timer_clock_en_next;
reg main_osc_en_next;
reg timer_osc_en_next;
reg cpu_halt_next;

always @* begin
    cpu_halt_next                = (state_reg != ST_RUN) && !halt_last;
    core_clock_en_next           = !gated;
    program_memory_clock_en_next = !gated;
    peripheral_io_clock_en_next  = !gated || io_kept(mode_reg);
    converter_clock_en_next      = !gated || adc_kept(mode_reg);
    async_timer_clock_en_next    = !gated || adc_kept(mode_reg) ||
                                   (has_async(mode_reg) && timer2_async_clock_bit);
    main_osc_en_next             = !asleep || osc_kept(mode_reg);
    timer_osc_en_next            = timer2_async_clock_bit &&
                                   (!gated || !tosc_stopped(mode_reg));
end

always @(posedge core_clk) begin
    if (reset) begin
        core_clock_en           <= 1'b1;
        program_memory_clock_en <= 1'b1;
        peripheral_io_clock_en  <= 1'b1;
        converter_clock_en      <= 1'b1;
        async_timer_clock_en    <= 1'b1;
        main_osc_en             <= 1'b1;
        timer_osc_en            <= 1'b1;
        cpu_halt                <= 1'b0;
    end else begin
        cpu_halt                <= cpu_halt_next;
        core_clock_en           <= core_clock_en_next;
        program_memory_clock_en <= program_memory_clock_en_next;
        peripheral_io_clock_en  <= peripheral_io_clock_en_next;
        converter_clock_en      <= converter_clock_en_next;
        async_timer_clock_en    <= async_timer_clock_en_next;
        main_osc_en             <= main_osc_en_next;
        timer_osc_en            <= timer_osc_en_next;
    end
end

endmodule // smcg_sleep_ctrl

/* hw/smcg_sync2.v */
// Purpose: two flip-flop synchroniser for asynchronous inputs
// Assumes: destination clock is core_clk
// Notes:   first stage feeds only the second stage
module smcg_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             core_clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;

always @(posedge core_clk) begin
    if (reset) begin
        meta_reg <= {WIDTH{1'b0}};
        sync_reg <= {WIDTH{1'b0}};
    end else begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end
end

assign sync_out = sync_reg;

endmodule // smcg_sync2

/* tb/smcg_sleep_ctrl_checker.sv */
// Purpose: port checks for the sleep controller
// Assumes: one clock, synchronous active-high reset
// Notes:   bound from the bench top file
module smcg_sleep_ctrl_checker (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sleep_instr,
    input wire logic core_clock_en,
    input wire logic program_memory_clock_en,
    input wire logic peripheral_io_clock_en,
    input wire logic converter_clock_en,
    input wire logic async_timer_clock_en,
    input wire logic main_osc_en,
    input wire logic timer_osc_en,
    input wire logic cpu_halt,
    input wire logic wake_event,
    input wire logic timer2_undefined
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    ////////////////////
    a_cpu_flash_pair: assert property (core_clock_en == program_memory_clock_en)
        else $error("core and flash clocks differ");
    a_adc_implies_io: assert property (!converter_clock_en |-> !peripheral_io_clock_en)
        else $error("io clock runs with converter clock stopped");
    a_osc_off_deep: assert property (!main_osc_en |-> !converter_clock_en)
        else $error("converter clock runs with main source off");
    a_halt_when_gated: assert property (!core_clock_en |-> cpu_halt)
        else $error("core clock stopped without halt");
    a_async_needs_osc: assert property (!converter_clock_en && async_timer_clock_en |-> timer_osc_en)
        else $error("async clock without timer oscillator");
    a_entry_after_instr: assert property ($rose(cpu_halt) |-> $past(sleep_instr, 2))
        else $error("sleep entered without sleep instruction");
    a_wake_one_shot: assert property (wake_event |=> !wake_event)
        else $error("wake pulse longer than one cycle");
    a_idle_resume: assert property (wake_event && $past(converter_clock_en) |-> cpu_halt[*3] ##[1:6] !cpu_halt)
        else $error("idle wake halt length wrong");
    a_standby_resume: assert property (wake_event && $past(main_osc_en) && !$past(converter_clock_en)
        |-> cpu_halt[*8] ##[1:8] !cpu_halt)
        else $error("standby wake time wrong");
    a_undef_gated: assert property ($rose(timer2_undefined) |-> ##[0:2] !timer_osc_en && !main_osc_en)
        else $error("undefined flag outside power save");
endmodule // smcg_sleep_ctrl_checker

/* tb/smcg_sleep_ctrl_tb_top.sv */
// Purpose: self-checking bench for the sleep controller
// Assumes: zero wait APB slave, startup count shortened to 2
// Notes:   wake sources come from the source model
`include "smcg_regs.vh"
module smcg_sleep_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        sleep_instr, global_irq_enable, irq_pending, ext_irq_zero, ext_irq_one;
    logic        spm_ready, adc_done, other_io_irq, cpu_halt, wake_event, timer2_undefined;
    logic [5:0]  fire, lvl;
    logic [6:0]  en;
    int          miscompares = 0;
    int          cmp_count = 0;
    logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [6:0]  gate [6] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02, 7'h07};
    logic [31:0] bad [4] = '{32'h3C, 32'h3D, 32'h1E, 32'h1F};
    smcg_wake_src smcg_wake_src_inst (.core_clk(core_clk), .fire(fire), .lvl(lvl));
    smcg_sleep_ctrl smcg_sleep_ctrl_inst (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_instr(sleep_instr),
        .global_irq_enable(global_irq_enable), .irq_pending(irq_pending),
        .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one), .ext_irq_two(lvl[0]),
        .ext_irq_zero_level(lvl[1]), .ext_irq_one_level(lvl[2]), .two_wire_match(lvl[3]),
        .timer2_overflow(lvl[4]), .timer2_compare(lvl[5]), .spm_ready(spm_ready),
        .adc_done(adc_done), .other_io_irq(other_io_irq), .core_clock_en(en[6]),
        .program_memory_clock_en(en[5]), .peripheral_io_clock_en(en[4]),
        .converter_clock_en(en[3]), .async_timer_clock_en(en[2]), .main_osc_en(en[1]),
        .timer_osc_en(en[0]), .cpu_halt(cpu_halt), .wake_event(wake_event),
        .timer2_undefined(timer2_undefined));
    ////////////////////
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        @(posedge core_clk);
        while (pready !== 1'h1) @(posedge core_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic pulse();
        @(posedge core_clk);
        sleep_instr <= 1'h1;
        @(posedge core_clk);
        sleep_instr <= 1'h0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic fire_src(input logic [5:0] m);
        @(posedge core_clk);
        fire <= m;
        @(posedge core_clk);
        fire <= 6'h00;
    endtask
    task automatic resume();
        int n;
        n = 0;
        while (cpu_halt !== 1'h0 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        #1;
        check("cpu_halt after wake", cpu_halt, 1'h0);
    endtask
    task automatic wait_check(input string n, input logic s);
        repeat (10) @(posedge core_clk);
        #1;
        check(n, s ? cpu_halt : 1'h1, 1'h1);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, sleep_instr, fire} = '0;
        {irq_pending, ext_irq_zero, ext_irq_one, spm_ready, adc_done, other_io_irq} = '0;
        global_irq_enable = 1'h1;
        reset = 1'h1;
        repeat (5) @(posedge core_clk);
        reset <= 1'h0;
        #1;
        check("reset enables", en[6:1], 6'h3F);
        apb(1'h0, `SMCG_ADDR_STARTUP, 32'h0);
        check("startup reset", q, {16'h0000, `SMCG_STARTUP_RESET});
        apb(1'h0, 8'h10, 32'h0);
        check("unmapped err", e, 1'h1);
        $display("test reset done");
        apb(1'h1, `SMCG_ADDR_CTRL, 32'h20);
        pulse();
        check("halt without enable", cpu_halt, 1'h0);
        apb(1'h1, `SMCG_ADDR_STARTUP, 32'h2);
        for (int i = 0; i < 6; i++) begin
            apb(1'h1, `SMCG_ADDR_CTRL, 32'h38 | modes[i]);
            pulse();
            check("gating", en, gate[i]);
            fire_src(6'h01);
            resume();
        end
        $display("test modes done");
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, `SMCG_ADDR_CTRL, bad[i]);
            pulse();
            check("refused halt", cpu_halt, 1'h0);
            check("refused enables", en[6:1], 6'h3F);
        end
        $display("test refusals done");
        apb(1'h1, `SMCG_ADDR_CTRL, 32'h2B);
        pulse();
        check("timer2 undefined", timer2_undefined, 1'h1);
        check("async clock off", en[2], 1'h0);
        @(posedge core_clk);
        ext_irq_zero <= 1'h1;
        fire_src(6'h10);
        wait_check("edge irq ignored", 1'h1);
        @(posedge core_clk);
        ext_irq_zero <= 1'h0;
        fire_src(6'h02);
        resume();
        $display("test power save sync done");
        apb(1'h1, `SMCG_ADDR_TMASK, 32'h0);
        apb(1'h1, `SMCG_ADDR_CTRL, 32'h3B);
        pulse();
        check("timer osc running", en[0], 1'h1);
        check("timer2 defined", timer2_undefined, 1'h0);
        fire_src(6'h10);
        wait_check("masked overflow", 1'h1);
        apb(1'h1, `SMCG_ADDR_TMASK, 32'h1);
        fire_src(6'h10);
        resume();
        $display("test timer2 wake done");
        print_verdict();
    end
endmodule // smcg_sleep_ctrl_tb_top

bind smcg_sleep_ctrl smcg_sleep_ctrl_checker chk (.core_clk(core_clk), .reset(reset),
    .sleep_instr(sleep_instr), .core_clock_en(core_clock_en),
    .program_memory_clock_en(program_memory_clock_en),
    .peripheral_io_clock_en(peripheral_io_clock_en), .converter_clock_en(converter_clock_en),
    .async_timer_clock_en(async_timer_clock_en), .main_osc_en(main_osc_en),
    .timer_osc_en(timer_osc_en), .cpu_halt(cpu_halt), .wake_event(wake_event),
    .timer2_undefined(timer2_undefined));

/* tb/smcg_wake_src.sv */
// Purpose: interrupt source model for synchronised wake inputs
// Assumes: one fire pulse per event
// Notes:   bits ext2, lvl0, lvl1, twi, t2ovf, t2cmp
module smcg_wake_src #(
    parameter int HOLD = 4
) (
    input  wire logic       core_clk,
    input  wire logic [5:0] fire,
    output logic      [5:0] lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial lvl = 6'h00;
    // level held past the sync and sample delay
    always @(posedge core_clk) begin
        if (fire != 6'h00) begin
            lvl <= fire;
            cnt <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            lvl <= 6'h00;
        end
    end
endmodule // smcg_wake_src
